// *** crc_engine_consts.svh ***
// Constants for the programmable CRC-16 engine: offsets, fields, resets, queue depth
`ifndef CRC_ENGINE_CONSTS_SVH
`define CRC_ENGINE_CONSTS_SVH
`define CRC_ADDR_DATA_IN      8'hb9
`define CRC_ADDR_RESULT_LOW   8'hba
`define CRC_ADDR_RESULT_HIGH  8'hbb
`define CRC_ADDR_POLY_LOW     8'hbc
`define CRC_ADDR_POLY_HIGH    8'hbd
`define CRC_ADDR_CONTROL      8'hbe
`define CRC_BIT_SEED          0
`define CRC_BIT_COMPLEMENT    1
`define CRC_BIT_REVERSE       2
`define CRC_BIT_DMA           3
`define CRC_BIT_CLEAR         7
`define CRC_CTRL_RW_MASK      8'h0f
`define CRC_RESET_BYTE        8'h00
`define CRC_SEED_ZEROS        16'h0000
`define CRC_SEED_ONES         16'hffff
`define CRC_FIFO_DEPTH        16
`endif

// *** crc_engine_pkg.sv ***
// Types for the programmable CRC-16 engine
package crc_engine_pkg;
	// Byte engine sequencer states, one-hot
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CALC = 2'b10
	} engine_state_type;
endpackage : crc_engine_pkg

// *** crc_byte_fifo.sv ***
// Parameterised FIFO holding bytes on their way to the CRC engine
`timescale 1ns/1ps
module crc_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	output      logic             in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output      logic             out_valid_o,
	input  wire logic             out_ready_i,
	output      logic [WIDTH-1:0] out_data_o,
	input  wire logic             flush_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];  // Storage array
	logic [AW-1:0]    wr_ptr_reg;   // Write index
	logic [AW-1:0]    rd_ptr_reg;   // Read index
	logic [AW:0]      count_reg;    // Words held
	wire              push;         // Word accepted
	wire              pop;          // Word drained
	assign in_ready_o  = (count_reg != (AW+1)'(DEPTH));
	assign out_valid_o = (count_reg != '0);
	assign push        = in_valid_i && in_ready_o && !flush_i;
	assign pop         = out_valid_o && out_ready_i && !flush_i;
	assign out_data_o  = mem[rd_ptr_reg];
	// Store accepted words
	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end
	// Pointers and occupancy; a flush empties the queue
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else if (flush_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : crc_byte_fifo

// *** crc_byte_step.sv ***
// Combinational one-byte step of the programmable CRC-16 shifter
`timescale 1ns/1ps
module crc_byte_step (
	input  wire logic [15:0] crc_i,
	input  wire logic [15:0] poly_i,
	input  wire logic [7:0]  data_i,
	output      logic [15:0] crc_o
);
	logic [15:0] stage [9];  // Value after each bit
	assign stage[0] = crc_i;
	// Shift each data bit in MSB first, x16 implicit
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_bit
			wire fb = stage[b][15] ^ data_i[7-b];
			assign stage[b+1] = {stage[b][14:0], 1'b0} ^ (fb ? poly_i : 16'h0000);
		end
	endgenerate
	assign crc_o = stage[8];
endmodule : crc_byte_step

// *** programmable_crc16_engine.sv ***
// Top of the programmable CRC-16 engine with register port and DMA feed
`timescale 1ns/1ps
`include "crc_engine_consts.svh"
module programmable_crc16_engine #(
	parameter int FIFO_DEPTH = `CRC_FIFO_DEPTH
) (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	input  wire logic [7:0] reg_wdata_i,
	output      logic [7:0] reg_rdata_o,
	output      logic       dma_req_o,
	input  wire logic       dma_wr_i,
	input  wire logic [7:0] dma_wdata_i,
	output      logic       busy_o
);
	// Register state
	logic [15:0] result_reg;     // Running CRC
	logic [7:0]  poly_low_reg;   // Polynomial low byte
	logic [7:0]  poly_high_reg;  // Polynomial high byte
	logic [3:0]  control_reg;    // Seed, complement, reverse, DMA
	logic [7:0]  data_in_reg;    // Last byte written
	logic [7:0]  rdata_reg;      // Read data
	logic [7:0]  byte_reg;       // Byte in the shifter
	crc_engine_pkg::engine_state_type state_reg;
	crc_engine_pkg::engine_state_type state_next;

	// Address decode
	wire sel_data  = (reg_addr_i == `CRC_ADDR_DATA_IN);
	wire sel_rlow  = (reg_addr_i == `CRC_ADDR_RESULT_LOW);
	wire sel_rhigh = (reg_addr_i == `CRC_ADDR_RESULT_HIGH);
	wire sel_plow  = (reg_addr_i == `CRC_ADDR_POLY_LOW);
	wire sel_phigh = (reg_addr_i == `CRC_ADDR_POLY_HIGH);
	wire sel_ctrl  = (reg_addr_i == `CRC_ADDR_CONTROL);

	// Control fields
	wire dma_mode   = control_reg[`CRC_BIT_DMA];
	wire seed_ones  = control_reg[`CRC_BIT_SEED];
	wire opt_rev    = control_reg[`CRC_BIT_REVERSE];
	wire opt_inv    = control_reg[`CRC_BIT_COMPLEMENT];
	wire ctrl_wr    = reg_wr_i && sel_ctrl;
	// Only the stored control bits survive; clear and reserved bits drop
	wire [7:0] ctrl_keep = reg_wdata_i & `CRC_CTRL_RW_MASK;
	// Clear is a strobe, never stored, so it reads zero afterwards
	wire clear_hit  = ctrl_wr && reg_wdata_i[`CRC_BIT_CLEAR];
	// Seed taken from the value in this same write, else the stored bit
	wire seed_now   = ctrl_wr ? reg_wdata_i[`CRC_BIT_SEED] : seed_ones;
	wire [15:0] seed_val = seed_now ? `CRC_SEED_ONES : `CRC_SEED_ZEROS;

	// Byte source: CPU writes, or DMA writes while in DMA mode
	wire cpu_byte   = reg_wr_i && sel_data;
	wire dma_byte   = dma_wr_i && dma_mode;
	wire push_valid = cpu_byte || dma_byte;
	// A DMA byte and a CPU byte in one cycle: the DMA byte wins and the
	// CPU byte is lost, as the queue takes one word per edge
	wire [7:0] push_data = dma_byte ? dma_wdata_i : reg_wdata_i;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire take_byte  = fifo_out_valid && (state_reg == crc_engine_pkg::ST_IDLE) && !clear_hit;

	// Queue between writers and the shifter; a clear drops pending bytes
	crc_byte_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys_i  (clk_sys_i),
		.rst_i      (rst_i),
		.in_valid_i (push_valid),
		.in_ready_o (fifo_in_ready),
		.in_data_i  (push_data),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(take_byte),
		.out_data_o (fifo_out_data),
		.flush_i    (clear_hit)
	);

	// Request a byte only while DMA mode is on and the queue has room
	assign dma_req_o = dma_mode && fifo_in_ready && !clear_hit;
	assign busy_o    = fifo_out_valid || (state_reg == crc_engine_pkg::ST_CALC);

	// One byte step through the polynomial
	wire [15:0] poly_val = {poly_high_reg, poly_low_reg};
	wire [15:0] step_crc;
	crc_byte_step u_step (
		.crc_i (result_reg),
		.poly_i(poly_val),
		.data_i(byte_reg),
		.crc_o (step_crc)
	);

	// Sequencer: take a byte, then finish it before the next
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			crc_engine_pkg::ST_IDLE: begin
				if (take_byte) begin
					state_next = crc_engine_pkg::ST_CALC;
				end
			end
			crc_engine_pkg::ST_CALC: begin
				state_next = crc_engine_pkg::ST_IDLE;
			end
			default: begin
				state_next = crc_engine_pkg::ST_IDLE;
			end
		endcase
		if (clear_hit) begin
			state_next = crc_engine_pkg::ST_IDLE;
		end
	end

	// Result views: bit reversal then complement
	wire [15:0] rev_view;
	genvar i;
	generate
		for (i = 0; i < 16; i++) begin : g_rev
			assign rev_view[i] = result_reg[15-i];
		end
	endgenerate
	wire [15:0] view_a = opt_rev ? rev_view : result_reg;
	wire [15:0] view   = opt_inv ? ~view_a : view_a;

	// Read multiplexer; reserved control bits read zero
	wire [7:0] rd_mux =
		sel_data  ? data_in_reg :
		sel_rlow  ? view[7:0] :
		sel_rhigh ? view[15:8] :
		sel_plow  ? poly_low_reg :
		sel_phigh ? poly_high_reg :
		sel_ctrl  ? {4'h0, control_reg} : `CRC_RESET_BYTE;

	// Sequencer state register
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= crc_engine_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// CRC result: clear reloads seed, else update after each byte
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			result_reg <= `CRC_SEED_ZEROS;
			byte_reg   <= `CRC_RESET_BYTE;
		end else if (clear_hit) begin
			result_reg <= seed_val;
		end else begin
			if (take_byte) begin
				byte_reg <= fifo_out_data;
			end
			if (state_reg == crc_engine_pkg::ST_CALC) begin
				result_reg <= step_crc;
			end
		end
	end

	// Software registers
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			poly_low_reg  <= `CRC_RESET_BYTE;
			poly_high_reg <= `CRC_RESET_BYTE;
			control_reg   <= 4'h0;
			data_in_reg   <= `CRC_RESET_BYTE;
		end else begin
			if (reg_wr_i && sel_plow) begin
				poly_low_reg <= reg_wdata_i;
			end
			if (reg_wr_i && sel_phigh) begin
				poly_high_reg <= reg_wdata_i;
			end
			if (ctrl_wr) begin
				control_reg <= ctrl_keep[3:0];
			end
			if (push_valid && fifo_in_ready) begin
				data_in_reg <= push_data;
			end
		end
	end

	// Registered read data
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= `CRC_RESET_BYTE;
		end else if (reg_rd_i) begin
			rdata_reg <= rd_mux;
		end
	end
	assign reg_rdata_o = rdata_reg;

	// Mirror of the result, written out bit by bit for the view checks
	wire [15:0] result_mirror = {
		result_reg[0],  result_reg[1],  result_reg[2],  result_reg[3],
		result_reg[4],  result_reg[5],  result_reg[6],  result_reg[7],
		result_reg[8],  result_reg[9],  result_reg[10], result_reg[11],
		result_reg[12], result_reg[13], result_reg[14], result_reg[15]};

	// Checks on the logic above; all run on the system clock and are held
	// off while reset is asserted, so reset values never trip them; each
	// one names the behaviour it guards
	// Clear loads the seed on the next edge
	a_clear_loads_seed: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		clear_hit |=> result_reg == $past(seed_val))
		else $error("clear did not load seed");

	// Clear empties the queue and parks the sequencer
	a_clear_flushes: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		clear_hit |=> !fifo_out_valid && state_reg == crc_engine_pkg::ST_IDLE)
		else $error("clear left work pending");

	// Clear bit never reads back as one
	a_clear_self_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(reg_rd_i && sel_ctrl) |=> !reg_rdata_o[7])
		else $error("clear bit read back set");

	// Seed ones gives all ones
	a_seed_polarity: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(clear_hit && reg_wdata_i[`CRC_BIT_SEED]) |=> result_reg == `CRC_SEED_ONES)
		else $error("seed polarity wrong");

	// Seed zero gives all zeros
	a_seed_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(clear_hit && !reg_wdata_i[`CRC_BIT_SEED]) |=> result_reg == `CRC_SEED_ZEROS)
		else $error("zero seed wrong");

	// No DMA request outside DMA mode
	a_dma_req_mode: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		dma_req_o |-> control_reg[3] && fifo_in_ready)
		else $error("DMA request outside DMA mode");

	// Control write stores the four mode bits
	a_ctrl_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ctrl_wr |=> control_reg == $past(reg_wdata_i[3:0]))
		else $error("control write not stored");

	// Reversed view is mirror of result
	a_reverse_view: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(opt_rev && !opt_inv) |-> view == result_mirror)
		else $error("reverse view wrong");

	// Complement view
	a_complement_view: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(opt_inv && !opt_rev) |-> view == ~result_reg)
		else $error("complement view wrong");

	// Both options: mirror, then complement
	a_both_views: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(opt_rev && opt_inv) |-> view == ~result_mirror)
		else $error("combined view wrong");

	// A taken byte updates result two edges later
	a_byte_update: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(take_byte && !clear_hit) ##1 !clear_hit |=> result_reg == $past(step_crc))
		else $error("byte not applied");

	// A queued byte is taken within two edges
	a_take_in_time: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		fifo_out_valid |-> ##[0:2] (take_byte || clear_hit))
		else $error("queued byte stalled");

	// Data input register captures a CPU byte the queue accepts with no DMA byte
	a_data_in_capture: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(cpu_byte && !dma_byte && fifo_in_ready) |=> data_in_reg == $past(reg_wdata_i))
		else $error("data input not captured");

	// DMA strobes outside DMA mode queue nothing
	a_dma_ignored: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(dma_wr_i && !dma_mode && !cpu_byte) |-> !push_valid)
		else $error("DMA byte taken outside DMA mode");

	// Polynomial low byte write
	a_poly_low_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(reg_wr_i && sel_plow) |=> poly_low_reg == $past(reg_wdata_i))
		else $error("poly low not stored");

	// Polynomial high byte write
	a_poly_high_write: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(reg_wr_i && sel_phigh) |=> poly_high_reg == $past(reg_wdata_i))
		else $error("poly high not stored");

	// Polynomial high byte reads back
	a_poly_readback: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(reg_rd_i && sel_phigh) |=> reg_rdata_o == $past(poly_high_reg))
		else $error("poly high read wrong");

	// Result only moves on a byte step or a clear
	a_result_stands: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state_reg != crc_engine_pkg::ST_CALC && !clear_hit) |=> $stable(result_reg))
		else $error("result moved without cause");

	// Plain read of the result low byte
	a_read_low_plain: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(reg_rd_i && sel_rlow && !opt_rev && !opt_inv) |=> reg_rdata_o == $past(result_reg[7:0]))
		else $error("result low read wrong");

	// Plain read of the result high byte
	a_read_high_plain: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(reg_rd_i && sel_rhigh && !opt_rev && !opt_inv) |=> reg_rdata_o == $past(result_reg[15:8]))
		else $error("result high read wrong");

	// Read data holds between reads
	a_read_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data changed without read");

	// Reserved control bits read zero
	a_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(reg_rd_i && sel_ctrl) |=> reg_rdata_o[6:4] == 3'b000)
		else $error("reserved bits nonzero");

	// Stored control bits read back
	a_ctrl_readback: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(reg_rd_i && sel_ctrl) |=> reg_rdata_o[3:0] == $past(control_reg))
		else $error("control read wrong");

	// A byte step lasts exactly one cycle
	a_calc_one_cycle: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state_reg == crc_engine_pkg::ST_CALC) |=> state_reg == crc_engine_pkg::ST_IDLE)
		else $error("byte step overran");

	// One byte at a time through the shifter
	a_one_byte_busy: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(state_reg == crc_engine_pkg::ST_CALC) |-> !take_byte)
		else $error("byte taken while busy");

	// Sequencer state stays one-hot
	a_state_onehot: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		$onehot(state_reg))
		else $error("sequencer state not one-hot");

	// No request while the queue is full
	a_full_no_req: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!fifo_in_ready |-> !dma_req_o)
		else $error("DMA request with full queue");
endmodule : programmable_crc16_engine

// *** crc_dma_model.sv ***
// DMA channel model feeding bytes into the CRC engine
`timescale 1ns/1ps
module crc_dma_model (
	input  wire logic       clk_sys_i,
	input  wire logic       rst_i,
	input  wire logic       dma_req_i,
	input  wire logic       start_i,
	input  wire logic [7:0] count_i,
	input  wire logic       slow_i,
	output      logic       dma_wr_o,
	output      logic [7:0] dma_wdata_o,
	output      logic       active_o
);
	logic [7:0] left_reg; // Bytes still to send
	logic [7:0] idx_reg;  // Index of the next byte
	logic       more;     // Another byte follows at once
	assign active_o = (left_reg != 8'h00);
	assign more = (left_reg != 8'h01) && !slow_i;
	// Hold each byte until the engine requests it; idle data toggles
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			left_reg <= 8'h00;
			idx_reg <= 8'h00;
			dma_wr_o <= 1'b0;
			dma_wdata_o <= 8'h00;
		end else if (start_i) begin
			left_reg <= count_i;
			idx_reg <= 8'h00;
		end else if (dma_wr_o && dma_req_i) begin
			left_reg <= left_reg - 8'h01;
			idx_reg <= idx_reg + 8'h01;
			dma_wr_o <= more;
			dma_wdata_o <= more ? 8'h31 + idx_reg : ~dma_wdata_o;
		end else if (!dma_wr_o && active_o) begin
			dma_wr_o <= 1'b1;
			dma_wdata_o <= 8'h30 + idx_reg;
		end else if (!dma_wr_o) begin
			dma_wdata_o <= ~dma_wdata_o;
		end
	end
endmodule : crc_dma_model

// *** tb_programmable_crc16_engine.sv ***
// Self-checking bench for the programmable CRC-16 engine
`timescale 1ns/1ps
`include "crc_engine_consts.svh"
module tb_programmable_crc16_engine;
	logic        clk_sys_i, rst_i, reg_wr_i, reg_rd_i, dma_wr_i, dma_req_o, busy_o;
	logic        start, slow, active, saw_full;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, dma_wdata_i, cnt;
	logic [15:0] crc, rv;
	int          error_cnt = 0;
	int          num_checks = 0;
	programmable_crc16_engine dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .dma_req_o(dma_req_o),
		.dma_wr_i(dma_wr_i), .dma_wdata_i(dma_wdata_i), .busy_o(busy_o));
	crc_dma_model dma_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .dma_req_i(dma_req_o),
		.start_i(start), .count_i(cnt), .slow_i(slow), .dma_wr_o(dma_wr_i),
		.dma_wdata_o(dma_wdata_i), .active_o(active));
	// Reference byte step: MSB first, shift left, x16 implicit
	function automatic logic [15:0] step(logic [15:0] c, logic [7:0] b);
		logic fb;
		for (int i = 7; i >= 0; i--) begin
			fb = c[15] ^ b[i];
			c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
		end
		return c;
	endfunction : step
	task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk8
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	// Read a register and compare one cycle later
	task automatic rdchk(logic [7:0] a, logic [7:0] e);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		@(posedge clk_sys_i);
		#1 chk8($sformatf("reg_%h", a), e, reg_rdata_o);
	endtask : rdchk
	task automatic chk_res(logic [15:0] e);
		rdchk(`CRC_ADDR_RESULT_LOW, e[7:0]);
		rdchk(`CRC_ADDR_RESULT_HIGH, e[15:8]);
	endtask : chk_res
	// Bounded wait until engine and DMA model are idle
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			#1 n++;
			if (active === 1'b1 && dma_req_o === 1'b0) saw_full = 1'b1;
		end while ((busy_o !== 1'b0 || active !== 1'b0) && n < 400);
		chk8("idle", 8'h01, {7'h00, n < 400});
	endtask : wait_idle
	task automatic dma_run(logic [7:0] n, logic s);
		@(posedge clk_sys_i);
		start <= 1'b1;
		cnt <= n;
		slow <= s;
		@(posedge clk_sys_i);
		start <= 1'b0;
		saw_full = 1'b0;
		wait_idle();
		for (int k = 0; k < n; k++) crc = step(crc, 8'h30 + k[7:0]);
	endtask : dma_run
	task automatic t_reset();
		for (int a = 'hb9; a < 'hc0; a++) rdchk(a[7:0], 8'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_cpu();
		wr(`CRC_ADDR_CONTROL, 8'h01);
		wr(`CRC_ADDR_CONTROL, 8'h81);
		rdchk(`CRC_ADDR_CONTROL, 8'h01);
		chk_res(16'hffff);
		wr(`CRC_ADDR_POLY_LOW, 8'h21);
		wr(`CRC_ADDR_POLY_HIGH, 8'h10);
		rdchk(`CRC_ADDR_POLY_HIGH, 8'h10);
		crc = 16'hffff;
		for (int k = 0; k < 9; k++) begin
			wr(`CRC_ADDR_DATA_IN, 8'h31 + k[7:0]);
			crc = step(crc, 8'h31 + k[7:0]);
		end
		wait_idle();
		chk_res(crc);
		rdchk(`CRC_ADDR_DATA_IN, 8'h39);
		wr(`CRC_ADDR_RESULT_LOW, 8'h55);
		chk_res(crc);
		wr(`CRC_ADDR_CONTROL, 8'h72);
		rdchk(`CRC_ADDR_CONTROL, 8'h02);
		chk_res(~crc);
		rv = {<<{crc}};
		wr(`CRC_ADDR_CONTROL, 8'h04);
		chk_res(rv);
		wr(`CRC_ADDR_CONTROL, 8'h06);
		chk_res(~rv);
		// Clear right behind two byte writes cancels the byte step still in the shifter
		wr(`CRC_ADDR_DATA_IN, 8'h12);
		wr(`CRC_ADDR_DATA_IN, 8'h34);
		wr(`CRC_ADDR_CONTROL, 8'h80);
		wait_idle();
		chk_res(16'h0000);
		$display("test cpu done");
	endtask : t_cpu
	task automatic t_dma();
		wr(`CRC_ADDR_CONTROL, 8'h81);
		wr(`CRC_ADDR_CONTROL, 8'h08);
		crc = 16'hffff;
		dma_run(8'h28, 1'b0);
		chk8("fifo_full_seen", 8'h01, {7'h00, saw_full});
		chk_res(crc);
		wr(`CRC_ADDR_CONTROL, 8'h80);
		wr(`CRC_ADDR_CONTROL, 8'h08);
		crc = 16'h0000;
		dma_run(8'h05, 1'b1);
		chk_res(crc);
		wr(`CRC_ADDR_CONTROL, 8'h00);
		#1 chk8("dma_req", 8'h00, {7'h00, dma_req_o});
		$display("test dma done");
	endtask : t_dma
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up
	// Clock of 4 ns period
	initial begin
		clk_sys_i = 1'b0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// Watchdog far beyond the expected run
	initial begin
		#100000;
		error_cnt++;
		wrap_up();
	end
	// Main sequence
	initial begin
		rst_i = 1'b1;
		{reg_wr_i, reg_rd_i, start, slow, saw_full} = '0;
		{reg_addr_i, reg_wdata_i, cnt} = '0;
		repeat (8) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		t_reset();
		t_cpu();
		t_dma();
		wrap_up();
	end
endmodule : tb_programmable_crc16_engine
